// ===== psr_pkg.sv
// shared constants and types for the pseudo static RAM bus and refresh controller
// assumes a 250 MHz system clock and an AHB-Lite register port with 32-bit words
package psr_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_RFM = 8'h00;
    localparam logic [7:0] OFF_MM = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_MACRO = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    // refresh_mode_reg fields
    localparam int RFM_SEL_LSB = 0;
    localparam int RFM_EN_BIT = 4;
    localparam int RFM_LVL_BIT = 7;
    // memory_expansion_mode_reg fields
    localparam int MM_WAIT_LO_BIT = 0;
    localparam int MM_WAIT_HI_BIT = 1;
    localparam int MM_EXTWAIT_BIT = 2;
    // macro request fields and register reset values
    localparam int MAC_TYPEC_BIT = 20;
    localparam int MAC_TOMEM_BIT = 21;
    localparam logic [7:0] RST_RFM = 8'h00;
    localparam logic [2:0] RST_MM = 3'h0;
    // address windows
    localparam logic [19:0] INT_RAM_END = 20'h0FEFF;
    localparam logic [19:0] SFR_INT_BASE = 20'h0FFE0;
    localparam logic [19:0] SFR_END = 20'h0FFFF;
    localparam logic [15:0] BUF_WIN_HI = 16'h0FED;
    localparam logic [3:0] DATA_WIN_HI = 4'hD;
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int REFRESH_OFF_NS = 200;
    localparam int REFRESH_OFF_CYC = (REFRESH_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REF_PULSE_CYC = 3;
    localparam int REF_BASE_CYC = 16;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] ad;
        logic ad_oe;
        logic address_strobe;
        logic rd_n;
        logic wr_n;
        logic refresh_request_pin_n;
    } psr_bus_out_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_REF} psr_state_t;
endpackage : psr_pkg

// ===== psr_ctrl.sv
// external bus sequencer with pulse and self refresh for pseudo static RAM
// assumes an AHB-Lite master on clk_i and external memory on a multiplexed bus
// Notes on behaviour
// R01 - enable set and level flag clear hold refresh request pin low
// R02 - refresh cycles and external accesses never overlap; each waits for the other
// R03 - no refresh pulse for about 200 ns after leaving self-refresh
// R04 - refresh request pin rises on leaving self-refresh only on a refresh timer tick
// R05 - level flag reads 1 once the request pin has actually gone high
// R06 - software never raises level flag while enable is already or simultaneously set
// R07 - software waits about 200 ns after exit before touching the RAM
// R08 - upper address stays valid from address strobe until strobe returns high
// R09 - internal RAM and internal register addresses are served inside
// R10 - internal accesses drive address but keep all strobes inactive
// R11 - type A memory-to-register move of D0-DF data also writes externally
// R12 - buffer or pointer in FED0-FEDF writes pointer low byte externally
// R13 - such writes run as normal writes with programmed wait states
// R14 - board decoder keeps 0FF00-0FFFF away from external circuits
// R15 - software sets port 6 direction bit 6 before using external wait
// R16 - with an emulator the board latches A16-A19
// R17 - level flag reads 0 in self-refresh, rises on synchronized pin edge
`timescale 1ns/1ps
module psr_ctrl #(
    parameter logic [19:0] INT_RAM_BASE = 20'h0FD00
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic [7:0] ad_i,
    input wire logic wait_n_i,
    input wire logic refresh_pin_sense_i,
    output psr_pkg::psr_bus_out_t bus_o
);
    psr_pkg::psr_state_t state_q;
    logic [7:0] wr_off_q, hrdata_q, rd_data_q, acc_data_q;
    logic wr_pend_q, acc_pend_q, acc_wr_q, acc_done, self_q, lvl_q, lvl_req_q, en_q, ref_pend_q;
    logic [1:0] sel_q, wait_cnt_q;
    logic ext_wait_q;
    logic [19:0] acc_addr_q;
    logic [6:0] tmr_q, period;
    logic [5:0] supp_q;
    logic [2:0] cnt_q;
    logic [1:0] wait_sync_q, sense_sync_q;
    logic sense_prev_q;
    logic [7:0] ad_s1_q, ad_s2_q;
    logic tick, sense_rise, busy, wr_go;
    function automatic logic is_internal(input logic [19:0] a);
        is_internal = (a >= INT_RAM_BASE && a <= psr_pkg::INT_RAM_END) ||
                      (a >= psr_pkg::SFR_INT_BASE && a <= psr_pkg::SFR_END);
    endfunction : is_internal
    function automatic logic in_buf_win(input logic [19:0] a);
        in_buf_win = (a[19:4] == psr_pkg::BUF_WIN_HI);
    endfunction : in_buf_win
    // ahb-lite: zero-wait slave, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = {24'h000000, hrdata_q};
    assign busy = acc_pend_q || (state_q != psr_pkg::ST_IDLE);
    assign wr_go = wr_pend_q && !busy;
    // address phase capture and registered read data
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 8'h00;
            hrdata_q <= 8'h00;
        end else begin
            wr_pend_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
            wr_off_q <= haddr_i[7:0];
            if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
                if (haddr_i[7:0] == psr_pkg::OFF_RFM) begin
                    hrdata_q <= {lvl_q, 2'b00, en_q, 2'b00, sel_q};
                end else if (haddr_i[7:0] == psr_pkg::OFF_MM) begin
                    hrdata_q <= {5'h00, ext_wait_q, wait_cnt_q};
                end else if (haddr_i[7:0] == psr_pkg::OFF_DATA) begin
                    hrdata_q <= rd_data_q;
                end else if (haddr_i[7:0] == psr_pkg::OFF_STATUS) begin
                    hrdata_q <= {5'h00, ref_pend_q, self_q, busy};
                end else begin
                    hrdata_q <= 8'h00;
                end
            end
        end
    end
    // software-written configuration
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sel_q <= psr_pkg::RST_RFM[1:0];
            en_q <= 1'b0;
            lvl_req_q <= 1'b0;
            wait_cnt_q <= psr_pkg::RST_MM[1:0];
            ext_wait_q <= 1'b0;
        end else if (wr_pend_q && wr_off_q == psr_pkg::OFF_RFM) begin
            sel_q <= hwdata_i[psr_pkg::RFM_SEL_LSB +: 2];
            en_q <= hwdata_i[psr_pkg::RFM_EN_BIT];
            lvl_req_q <= hwdata_i[psr_pkg::RFM_LVL_BIT];
        end else if (wr_pend_q && wr_off_q == psr_pkg::OFF_MM) begin
            wait_cnt_q <= {hwdata_i[psr_pkg::MM_WAIT_HI_BIT], hwdata_i[psr_pkg::MM_WAIT_LO_BIT]};
            ext_wait_q <= hwdata_i[psr_pkg::MM_EXTWAIT_BIT];
        end
    end
    // access request; starts are ignored while busy, so address holds for the whole access
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_pend_q <= 1'b0;
            acc_wr_q <= 1'b0;
            acc_addr_q <= 20'h00000;
            acc_data_q <= 8'h00;
        end else begin
            if (acc_done) begin
                acc_pend_q <= 1'b0;
            end
            if (wr_pend_q && wr_off_q == psr_pkg::OFF_ADDR && !busy) begin
                acc_addr_q <= hwdata_i[19:0];
            end else if (wr_go && wr_off_q == psr_pkg::OFF_DATA) begin
                acc_data_q <= hwdata_i[7:0];
                acc_wr_q <= 1'b1;
                acc_pend_q <= !is_internal(acc_addr_q); // R09 R10
            end else if (wr_go && wr_off_q == psr_pkg::OFF_CTRL && hwdata_i[0]) begin
                acc_wr_q <= 1'b0;
                acc_pend_q <= 1'b1;
            end else if (wr_go && wr_off_q == psr_pkg::OFF_MACRO) begin
                // register target stays in acc_addr_q; the stray write goes there
                acc_wr_q <= 1'b1;
                if (!hwdata_i[psr_pkg::MAC_TYPEC_BIT] && !hwdata_i[psr_pkg::MAC_TOMEM_BIT]) begin
                    acc_pend_q <= (acc_data_q[7:4] == psr_pkg::DATA_WIN_HI); // R11
                end else begin
                    acc_pend_q <= in_buf_win(hwdata_i[19:0]); // R12
                    acc_data_q <= hwdata_i[7:0]; // R12
                end
            end
        end
    end
    // pin synchronisers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_sync_q <= 2'b11;
            sense_sync_q <= 2'b11;
            sense_prev_q <= 1'b1;
            ad_s1_q <= 8'h00;
            ad_s2_q <= 8'h00;
        end else begin
            wait_sync_q <= {wait_sync_q[0], wait_n_i};
            sense_sync_q <= {sense_sync_q[0], refresh_pin_sense_i};
            sense_prev_q <= sense_sync_q[1];
            ad_s1_q <= ad_i;
            ad_s2_q <= ad_s1_q;
        end
    end
    assign sense_rise = sense_sync_q[1] && !sense_prev_q;
    // refresh interval timer: 16, 32, 64 or 128 cycles
    assign period = 7'(psr_pkg::REF_BASE_CYC << sel_q);
    assign tick = (tmr_q == 7'(period - 7'd1));
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tmr_q <= 7'h00;
        end else begin
            tmr_q <= tick ? 7'h00 : 7'(tmr_q + 7'd1);
        end
    end
    // self-refresh entry, exit aligned to the timer, then a quiet period
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            self_q <= 1'b0;
            supp_q <= 6'h00;
        end else begin
            if (!self_q && en_q && !lvl_req_q && state_q == psr_pkg::ST_IDLE) begin
                self_q <= 1'b1; // R01 R02
            end else if (self_q && (lvl_req_q || !en_q) && tick) begin
                self_q <= 1'b0; // R04
            end
            if (self_q && (lvl_req_q || !en_q) && tick) begin
                supp_q <= 6'(psr_pkg::REFRESH_OFF_CYC); // R03
            end else if (supp_q != 6'h00) begin
                supp_q <= 6'(supp_q - 6'd1);
            end
        end
    end
    // level flag: cleared in self-refresh, set by the real pin edge outside it; the edge wins over a software clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lvl_q <= 1'b0;
        end else if (sense_rise && !self_q) begin
            lvl_q <= 1'b1; // R05 R17
        end else if (self_q || (wr_pend_q && wr_off_q == psr_pkg::OFF_RFM &&
                                !hwdata_i[psr_pkg::RFM_LVL_BIT])) begin
            lvl_q <= 1'b0; // R17
        end
    end
    // pulse refresh request, held until the bus is free
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_pend_q <= 1'b0;
        end else if (tick && en_q && lvl_req_q && !self_q && supp_q == 6'h00) begin
            ref_pend_q <= 1'b1; // R03
        end else if (state_q == psr_pkg::ST_REF) begin
            ref_pend_q <= 1'b0;
        end
    end
    // bus sequencer; refresh has priority at idle, neither preempts the other
    assign acc_done = (state_q == psr_pkg::ST_IDLE && !ref_pend_q && acc_pend_q &&
                       is_internal(acc_addr_q) && !acc_wr_q) ||
                      (state_q == psr_pkg::ST_STROBE && cnt_q == 3'h0 &&
                       !(ext_wait_q && !wait_sync_q[1]));
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= psr_pkg::ST_IDLE;
            cnt_q <= 3'h0;
            rd_data_q <= 8'h00;
        end else begin
            case (state_q)
                psr_pkg::ST_IDLE: begin
                    if (ref_pend_q && !self_q) begin
                        state_q <= psr_pkg::ST_REF; // R02
                        cnt_q <= 3'(psr_pkg::REF_PULSE_CYC - 1);
                    end else if (acc_pend_q && (!is_internal(acc_addr_q) || acc_wr_q)) begin
                        state_q <= psr_pkg::ST_ADDR; // R09
                    end
                end
                psr_pkg::ST_ADDR: begin
                    state_q <= psr_pkg::ST_STROBE;
                    cnt_q <= {1'b0, wait_cnt_q}; // R13
                end
                psr_pkg::ST_STROBE: begin
                    if (cnt_q != 3'h0) begin
                        cnt_q <= 3'(cnt_q - 3'd1);
                    end else if (acc_done) begin
                        state_q <= psr_pkg::ST_IDLE;
                        if (!acc_wr_q) begin
                            rd_data_q <= ad_s2_q;
                        end
                    end
                end
                default: begin
                    if (cnt_q != 3'h0) begin
                        cnt_q <= 3'(cnt_q - 3'd1);
                    end else begin
                        state_q <= psr_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end
    // pin drive; internal reads keep strobes quiet, address still shown
    always_comb begin
        bus_o.addr = acc_addr_q; // R08 R10
        bus_o.ad = acc_data_q;
        bus_o.ad_oe = acc_wr_q && (state_q == psr_pkg::ST_STROBE);
        bus_o.address_strobe = (state_q == psr_pkg::ST_ADDR); // R10
        bus_o.rd_n = !(state_q == psr_pkg::ST_STROBE && !acc_wr_q);
        bus_o.wr_n = !(state_q == psr_pkg::ST_STROBE && acc_wr_q);
        bus_o.refresh_request_pin_n = !(self_q || state_q == psr_pkg::ST_REF); // R01
    end
    // helper: length of the low write strobe
    logic [3:0] wr_len_q;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_len_q <= 4'h0;
        end else begin
            wr_len_q <= bus_o.wr_n ? 4'h0 : 4'(wr_len_q + 4'd1);
        end
    end
    a_self_entry: assert property (@(posedge clk_i) disable iff (reset_i) // R01
        $rose(self_q) |-> $past(en_q) && !$past(lvl_req_q) && !bus_o.refresh_request_pin_n)
        else $error("self-refresh entered without enable");
    a_no_overlap: assert property (@(posedge clk_i) disable iff (reset_i) // R02
        state_q == psr_pkg::ST_REF |-> !bus_o.address_strobe && bus_o.rd_n && bus_o.wr_n)
        else $error("refresh overlaps an access");
    a_quiet_exit: assert property (@(posedge clk_i) disable iff (reset_i) // R03
        $fell(self_q) |-> (state_q != psr_pkg::ST_REF && !ref_pend_q)[*8])
        else $error("refresh pulse inside disabled period");
    a_exit_tick: assert property (@(posedge clk_i) disable iff (reset_i) // R04
        $fell(self_q) |-> $past(tick))
        else $error("pin released off the timer tick");
    a_flag_edge: assert property (@(posedge clk_i) disable iff (reset_i) // R05
        $rose(lvl_q) |-> $past(sense_sync_q[1]) && !$past(sense_prev_q))
        else $error("level flag set without pin edge");
    a_flag_low: assert property (@(posedge clk_i) disable iff (reset_i) // R17
        self_q |=> !lvl_q)
        else $error("level flag high in self-refresh");
    a_addr_hold: assert property (@(posedge clk_i) disable iff (reset_i) // R08
        !bus_o.rd_n || !bus_o.wr_n |-> $stable(bus_o.addr))
        else $error("address moved during access");
    a_int_quiet: assert property (@(posedge clk_i) disable iff (reset_i) // R10
        bus_o.address_strobe |-> !is_internal(bus_o.addr) || acc_wr_q)
        else $error("strobe on internal read");
    a_illegal_wr: assert property (@(posedge clk_i) disable iff (reset_i) // R11
        wr_go && wr_off_q == psr_pkg::OFF_MACRO && !hwdata_i[psr_pkg::MAC_TYPEC_BIT] &&
        !hwdata_i[psr_pkg::MAC_TOMEM_BIT] && acc_data_q[7:4] == 4'hD |=> acc_pend_q && acc_wr_q)
        else $error("stray write not issued");
    a_wait_len: assert property (@(posedge clk_i) disable iff (reset_i) // R13
        $rose(bus_o.wr_n) && !ext_wait_q |-> wr_len_q == 4'({2'b00, wait_cnt_q} + 4'd1))
        else $error("write strobe length wrong");
endmodule : psr_ctrl

// ===== psr_mem_model.sv
// memory and board model on the far side of the multiplexed bus
// assumes the controller bus struct and the shared system clock
`timescale 1ns/1ps
module psr_mem_model (
    input wire logic clk_i,
    input wire psr_pkg::psr_bus_out_t bus_i,
    input wire logic [3:0] stall_i,
    output logic [7:0] ad_o,
    output logic wait_n_o,
    output logic [19:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic [3:0] wr_len_o,
    output int wr_cnt_o,
    output int stb_cnt_o,
    output int addr_err_o
);
    logic [19:0] lat_q = 20'h00000;
    logic [7:0] mem_q [16];
    logic [7:0] last_q = 8'h00;
    logic [3:0] len_q = 4'h0;
    logic [3:0] stall_q = 4'h0;
    // counters start clear, memory starts blank
    initial begin
        wr_cnt_o = 0;
        stb_cnt_o = 0;
        addr_err_o = 0;
        foreach (mem_q[i]) mem_q[i] = 8'h00;
    end
    // released bus shows the inverse of the last byte, so a stale value never passes
    assign ad_o = !bus_i.rd_n ? mem_q[lat_q[3:0]] : ~last_q;
    assign wait_n_o = (stall_q == 4'h0);
    // address latch on the strobe, wait stretch and write capture
    always @(posedge clk_i) begin
        if (!bus_i.rd_n) last_q <= mem_q[lat_q[3:0]];
        if (bus_i.address_strobe) begin
            lat_q <= bus_i.addr;
            stall_q <= stall_i;
            stb_cnt_o <= stb_cnt_o + 1;
        end
        if ((!bus_i.rd_n || !bus_i.wr_n) && stall_q != 4'h0) stall_q <= stall_q - 4'h1;
        if ((!bus_i.rd_n || !bus_i.wr_n) && bus_i.addr !== lat_q) addr_err_o <= addr_err_o + 1;
        if (!bus_i.wr_n) begin
            len_q <= len_q + 4'h1;
            wr_data_o <= bus_i.ad_oe ? bus_i.ad : ~bus_i.ad; // undriven bus reads back inverted
        end else if (len_q != 4'h0) begin
            len_q <= 4'h0;
            wr_len_o <= len_q;
            wr_addr_o <= lat_q;
            wr_cnt_o <= wr_cnt_o + 1;
            // the board decoder keeps the register area off every external part
            if (lat_q[19:8] != 12'h0FF) mem_q[lat_q[3:0]] <= wr_data_o;
        end
    end
endmodule : psr_mem_model

// ===== psr_ctrl_bench.sv
// self-checking bench for the bus and refresh controller
// assumes the package and the memory model are compiled first
`timescale 1ns/1ps
module psr_ctrl_bench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic hready, hresp, wait_n;
    logic [31:0] hrdata, rd;
    logic [7:0] ad, wr_data;
    logic [3:0] stall = 4'h0;
    logic [3:0] wr_len;
    logic [19:0] wr_addr;
    psr_pkg::psr_bus_out_t bus;
    int wr_cnt, stb_cnt, addr_err, n0;
    int error_cnt = 0;
    int check_count = 0;
    int overlap = 0, low_len = 0, last_low = 0, since_rise = 1000;
    logic [19:0] win [5] = '{20'h0FD00, 20'h0FEFF, 20'h0FFE0, 20'h0FFFF, 20'h0FCFF};
    logic [31:0] mdat [6] = '{32'hD5, 32'hC5, 32'h00, 32'h00, 32'h00, 32'h00};
    logic [31:0] mreq [6] = '{32'h0, 32'h0, 32'h20FED3, 32'h20FEE3, 32'h10FED7, 32'h10FEC7};
    logic [7:0] mexp [6] = '{8'hD5, 8'h00, 8'hD3, 8'h00, 8'hD7, 8'h00};
    always #2 clk_i = ~clk_i;
    psr_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .ad_i(ad), .wait_n_i(wait_n), .refresh_pin_sense_i(bus.refresh_request_pin_n),
        .bus_o(bus));
    psr_mem_model mem (.clk_i(clk_i), .bus_i(bus), .stall_i(stall), .ad_o(ad),
        .wait_n_o(wait_n), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_len_o(wr_len),
        .wr_cnt_o(wr_cnt), .stb_cnt_o(stb_cnt), .addr_err_o(addr_err));
    // watch pin pulse width, gap after each rise, and strobes during refresh
    always @(posedge clk_i) begin
        if (!bus.refresh_request_pin_n && (bus.address_strobe || !bus.rd_n || !bus.wr_n))
            overlap <= overlap + 1;
        if (!bus.refresh_request_pin_n) low_len <= low_len + 1;
        else if (low_len != 0) since_rise <= 0;
        else since_rise <= since_rise + 1;
        if (bus.refresh_request_pin_n && low_len != 0) last_low <= low_len;
        if (bus.refresh_request_pin_n) low_len <= 0;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hready !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 100) error_cnt++;
    endtask : wait_ready
    // one single word transfer; an idle cycle first keeps drivers one change per step
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : ahb
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            ahb(1'b0, psr_pkg::OFF_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 200);
        if (n >= 200) error_cnt++;
    endtask : wait_idle
    task automatic wait_pin(input logic lvl);
        int n;
        n = 0;
        while (bus.refresh_request_pin_n !== lvl && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        check("refresh pin", bus.refresh_request_pin_n, lvl);
    endtask : wait_pin
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // watchdog sized well past the whole sequence
    initial begin
        #80000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        ahb(1'b0, psr_pkg::OFF_RFM, 32'h0);
        check("rfm reset", rd, {24'h000000, psr_pkg::RST_RFM});
        ahb(1'b0, psr_pkg::OFF_MM, 32'h0);
        check("mm reset", rd, {29'h00000000, psr_pkg::RST_MM});
        ahb(1'b0, 8'h1C, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("okay response", hresp, 1'b0);
        check("pin idle", bus.refresh_request_pin_n, 1'b1);
        $display("test reset done");
        // plain write then read back with two programmed waits
        ahb(1'b1, psr_pkg::OFF_MM, 32'h2);
        ahb(1'b1, psr_pkg::OFF_ADDR, 32'h20005);
        ahb(1'b1, psr_pkg::OFF_DATA, 32'hA5);
        wait_idle();
        check("write address", {12'h000, wr_addr}, 32'h20005);
        check("write data", wr_data, 8'hA5);
        check("write length", wr_len, 4'h3);
        ahb(1'b1, psr_pkg::OFF_CTRL, 32'h1);
        wait_idle();
        ahb(1'b0, psr_pkg::OFF_DATA, 32'h0);
        check("read back", rd, 32'hA5);
        $display("test external access done");
        // internal windows stay silent, the byte below goes out
        foreach (win[i]) begin
            n0 = stb_cnt;
            ahb(1'b1, psr_pkg::OFF_ADDR, {12'h000, win[i]});
            ahb(1'b1, psr_pkg::OFF_CTRL, 32'h1);
            wait_idle();
            ahb(1'b1, psr_pkg::OFF_DATA, 32'h5A);
            wait_idle();
            check("strobes", stb_cnt - n0, (i == 4) ? 2 : 0);
            check("address out", bus.addr, win[i]);
        end
        $display("test internal windows done");
        // external wait on top of two programmed waits; the memory model stalls the access
        ahb(1'b1, psr_pkg::OFF_MM, 32'h6);
        stall <= 4'h6;
        ahb(1'b1, psr_pkg::OFF_ADDR, 32'h20007);
        ahb(1'b1, psr_pkg::OFF_DATA, 32'h3C);
        wait_idle();
        check("wait stretch", wr_len > 4'h3, 1'b1);
        stall <= 4'h0;
        $display("test external wait done");
        // stray writes from transfer requests, one wait programmed
        ahb(1'b1, psr_pkg::OFF_MM, 32'h1);
        ahb(1'b1, psr_pkg::OFF_ADDR, 32'h0FF10);
        foreach (mreq[i]) begin
            ahb(1'b1, psr_pkg::OFF_DATA, mdat[i]);
            wait_idle();
            n0 = wr_cnt;
            ahb(1'b1, psr_pkg::OFF_MACRO, mreq[i]);
            wait_idle();
            check("stray count", wr_cnt - n0, mexp[i] != 8'h00);
            if (mexp[i] != 8'h00) check("stray data", wr_data, mexp[i]);
            if (mexp[i] != 8'h00) check("stray length", wr_len, 4'h2);
        end
        check("address held", addr_err, 0);
        $display("test stray writes done");
        // self-refresh entry, hold, then exit into pulse mode
        ahb(1'b1, psr_pkg::OFF_RFM, 32'h10);
        wait_pin(1'b0);
        repeat (30) @(posedge clk_i);
        check("pin held", bus.refresh_request_pin_n, 1'b0);
        ahb(1'b0, psr_pkg::OFF_RFM, 32'h0);
        check("flag in self refresh", rd[7], 1'b0);
        ahb(1'b1, psr_pkg::OFF_RFM, 32'h0);
        wait_pin(1'b1);
        ahb(1'b1, psr_pkg::OFF_RFM, 32'h80);
        ahb(1'b1, psr_pkg::OFF_RFM, 32'h90);
        ahb(1'b0, psr_pkg::OFF_RFM, 32'h0);
        check("flag after exit", rd[7], 1'b1);
        wait_pin(1'b0);
        check("quiet after rise", since_rise >= psr_pkg::REFRESH_OFF_CYC, 1'b1);
        // memory access only after the recovery time has passed
        repeat (psr_pkg::REFRESH_OFF_CYC) @(posedge clk_i);
        ahb(1'b1, psr_pkg::OFF_MM, 32'h0);
        for (int k = 0; k < 8; k++) begin
            ahb(1'b1, psr_pkg::OFF_DATA, 32'h40 + k);
            wait_idle();
        end
        repeat (20) @(posedge clk_i);
        check("no overlap", overlap, 0);
        check("pulse width", last_low, psr_pkg::REF_PULSE_CYC);
        $display("test refresh done");
        tally_and_finish();
    end
endmodule : psr_ctrl_bench
